//--- verilog/sltq_switch.v
// Regulation selector between torque and velocity regulation,
// with an AXI4-Lite register slave.
// Assumes inputs synchronous to sys_clk and a velocity regulator
// outside that supplies its torque output each sample.
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sltq_defs.vh"

module sltq_switch #(
    parameter DW         = 32,
    parameter AW         = 8,
    parameter SAMPLE_DIV = `SLTQ_SAMPLE_CYC
) (
    input  wire          sys_clk,
    input  wire          nrst,
    input  wire [AW-1:0] s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [AW-1:0] s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    input  wire [DW-1:0] speed_feedback,
    input  wire [DW-1:0] vel_loop_torque,
    output reg  [DW-1:0] speed_reference,
    output reg  [DW-1:0] torque_setpoint,
    output reg           speed_ctrl_on,
    output reg           sample_strobe
);

    localparam ST_TORQUE = 1'b0;
    localparam ST_VEL    = 1'b1;

    // Byte-lane merge used by every writable register
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // Word-aligned address compare, low two bits ignored
    function hit;
        input [AW-1:0] a;
        input [7:0]    ofs;
        begin
            hit = ({a[AW-1:2], 2'b00} == ofs[AW-1:0]);
        end
    endfunction

    reg  [31:0]   config_r;
    reg  [31:0]   thresh_r;
    reg  [31:0]   dwell_r;
    reg  [31:0]   speed_cmd_r;
    reg  [31:0]   torque_ofs_r;
    reg           state_r;
    reg  [31:0]   dwell_cnt_r;
    reg  [DW-1:0] disp_err_r;
    reg  [31:0]   div_cnt_r;
    reg           aw_full_r;
    reg  [AW-1:0] awaddr_r;
    reg           w_full_r;
    reg  [31:0]   wdata_r;
    reg  [3:0]    wstrb_r;
    reg  [31:0]   rd_nxt;
    reg           rd_err_nxt;

    wire [1:0]    mode = config_r[`SLTQ_CFG_MODE_MSB:`SLTQ_CFG_MODE_LSB];
    wire          inv  = config_r[`SLTQ_CFG_INV_BIT];
    wire          mode_min = (mode == `SLTQ_MODE_MIN);
    wire          mode_max = (mode == `SLTQ_MODE_MAX);
    // Unknown code 3 falls back to the plain velocity loop
    wire          switching = mode_min | mode_max;

    // One extra bit so command minus feedback never wraps
    wire signed [DW:0] err_s =
        $signed({speed_cmd_r[DW-1], speed_cmd_r[DW-1:0]})
        - $signed({speed_feedback[DW-1], speed_feedback});
    wire signed [DW:0] thr_s =
        $signed({thresh_r[DW-1], thresh_r[DW-1:0]});
    wire signed [DW-1:0] ofs_s  = $signed(torque_ofs_r[DW-1:0]);
    wire signed [DW-1:0] loop_s = $signed(vel_loop_torque);

    wire          go_vel  = (mode_min & (err_s < 0))
                          | (mode_max & (err_s > 0));
    wire          ret_ok  = (mode_min & (err_s > thr_s))
                          | (mode_max & (err_s < thr_s));
    wire [31:0]   cnt_inc = dwell_cnt_r + 32'h0000_0001;
    wire          dwell_done = (cnt_inc >= dwell_r);
    wire          sel_ofs_min = (ofs_s < loop_s);
    wire          sel_ofs_max = (ofs_s > loop_s);
    // Setpoint of the selected setting on the tick that returns to torque
    wire [DW-1:0] trq_pick = (mode_min ? sel_ofs_min : sel_ofs_max) ?
                             torque_ofs_r[DW-1:0] : vel_loop_torque;
    wire          tick = (div_cnt_r == SAMPLE_DIV - 1);

    // Sample rate divider
    always @(posedge sys_clk) begin
        if (!nrst) begin
            div_cnt_r     <= 32'h0000_0000;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= tick;
            if (tick) begin
                div_cnt_r <= 32'h0000_0000;
            end else begin
                div_cnt_r <= div_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Regulation choice, updated only on a sample tick
    always @(posedge sys_clk) begin
        if (!nrst) begin
            state_r         <= ST_TORQUE;
            dwell_cnt_r     <= 32'h0000_0000;
            disp_err_r      <= {DW{1'b0}};
            torque_setpoint <= {DW{1'b0}};
            speed_ctrl_on   <= 1'b1;
            speed_reference <= {DW{1'b0}};
        end else if (tick) begin
            speed_reference <= speed_cmd_r[DW-1:0];
            // Shown error flips with inversion; decisions do not
            disp_err_r <= inv ? -err_s[DW-1:0] : err_s[DW-1:0];
            if (!switching) begin
                state_r         <= ST_TORQUE;
                dwell_cnt_r     <= 32'h0000_0000;
                speed_ctrl_on   <= 1'b1;
                torque_setpoint <= vel_loop_torque;
            end else begin
                case (state_r)
                    ST_TORQUE: begin
                        dwell_cnt_r <= 32'h0000_0000;
                        if (go_vel) begin
                            state_r         <= ST_VEL;
                            speed_ctrl_on   <= 1'b1;
                            torque_setpoint <= vel_loop_torque;
                        end else begin
                            speed_ctrl_on <= 1'b0;
                            if (mode_min) begin
                                torque_setpoint <= sel_ofs_min ?
                                    torque_ofs_r[DW-1:0] : vel_loop_torque;
                            end else begin
                                torque_setpoint <= sel_ofs_max ?
                                    torque_ofs_r[DW-1:0] : vel_loop_torque;
                            end
                        end
                    end
                    ST_VEL: begin
                        speed_ctrl_on   <= 1'b1;
                        torque_setpoint <= vel_loop_torque;
                        if (ret_ok) begin
                            if (dwell_done) begin
                                // Return shows on the same tick, not one sample late
                                state_r         <= ST_TORQUE;
                                dwell_cnt_r     <= 32'h0000_0000;
                                speed_ctrl_on   <= 1'b0;
                                torque_setpoint <= trq_pick;
                            end else begin
                                dwell_cnt_r <= cnt_inc;
                            end
                        end else begin
                            dwell_cnt_r <= 32'h0000_0000;
                        end
                    end
                    default: begin
                        state_r <= ST_TORQUE;
                    end
                endcase
            end
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SLTQ_RESP_OKAY;
            aw_full_r     <= 1'b0;
            awaddr_r      <= {AW{1'b0}};
            w_full_r      <= 1'b0;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            config_r      <= `SLTQ_RST_CONFIG;
            thresh_r      <= `SLTQ_RST_THRESH;
            dwell_r       <= `SLTQ_RST_DWELL;
            speed_cmd_r   <= `SLTQ_RST_SPEED;
            torque_ofs_r  <= `SLTQ_RST_TORQUE;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                awaddr_r      <= s_axi_awaddr;
                aw_full_r     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_full_r     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_full_r && w_full_r && !s_axi_bvalid) begin
                aw_full_r    <= 1'b0;
                w_full_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `SLTQ_RESP_OKAY;
                if (hit(awaddr_r, `SLTQ_OFS_CONFIG)) begin
                    config_r <= merge(config_r, wdata_r, wstrb_r);
                end else if (hit(awaddr_r, `SLTQ_OFS_THRESH)) begin
                    thresh_r <= merge(thresh_r, wdata_r, wstrb_r);
                end else if (hit(awaddr_r, `SLTQ_OFS_DWELL)) begin
                    dwell_r <= merge(dwell_r, wdata_r, wstrb_r);
                end else if (hit(awaddr_r, `SLTQ_OFS_SPEED)) begin
                    speed_cmd_r <= merge(speed_cmd_r, wdata_r, wstrb_r);
                end else if (hit(awaddr_r, `SLTQ_OFS_TORQUE)) begin
                    torque_ofs_r <= merge(torque_ofs_r, wdata_r, wstrb_r);
                end else begin
                    // Read-only and unmapped words refuse the write
                    s_axi_bresp <= `SLTQ_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read data selection
    always @* begin
        rd_nxt     = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        if (hit(s_axi_araddr, `SLTQ_OFS_CONFIG)) begin
            rd_nxt[`SLTQ_CFG_MODE_MSB:`SLTQ_CFG_MODE_LSB] = mode;
            rd_nxt[`SLTQ_CFG_INV_BIT] = inv;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_THRESH)) begin
            rd_nxt = thresh_r;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_DWELL)) begin
            rd_nxt = dwell_r;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_SPEED)) begin
            rd_nxt = speed_cmd_r;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_TORQUE)) begin
            rd_nxt = torque_ofs_r;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_STATUS)) begin
            rd_nxt[`SLTQ_ST_VEL_BIT] = speed_ctrl_on;
            rd_nxt[`SLTQ_ST_DIS_BIT] = ~switching;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_SPD_ERR)) begin
            rd_nxt[DW-1:0] = disp_err_r;
        end else if (hit(s_axi_araddr, `SLTQ_OFS_DWL_CNT)) begin
            rd_nxt = dwell_cnt_r;
        end else begin
            rd_err_nxt = 1'b1;
        end
    end

    // Read channel, one read outstanding
    always @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `SLTQ_RESP_OKAY;
        end else begin
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_nxt;
                s_axi_rresp   <= rd_err_nxt ? `SLTQ_RESP_SLVERR
                                            : `SLTQ_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- verilog/sltq_defs.vh
// Constants for the speed limited torque switch: register map,
// field positions, reset values, encodings and timing.
// Assumes a 250 MHz system clock and 32-bit AXI4-Lite data.
`ifndef SLTQ_DEFS_VH
`define SLTQ_DEFS_VH

`define SLTQ_OFS_CONFIG   8'h00
`define SLTQ_OFS_THRESH   8'h04
`define SLTQ_OFS_DWELL    8'h08
`define SLTQ_OFS_SPEED    8'h0C
`define SLTQ_OFS_TORQUE   8'h10
`define SLTQ_OFS_STATUS   8'h14
`define SLTQ_OFS_SPD_ERR  8'h18
`define SLTQ_OFS_DWL_CNT  8'h1C

`define SLTQ_CFG_MODE_LSB 0
`define SLTQ_CFG_MODE_MSB 1
`define SLTQ_CFG_INV_BIT  4
`define SLTQ_ST_VEL_BIT   0
`define SLTQ_ST_DIS_BIT   1

`define SLTQ_MODE_OFF     2'h0
`define SLTQ_MODE_MIN     2'h1
`define SLTQ_MODE_MAX     2'h2

`define SLTQ_RST_CONFIG   32'h0000_0000
`define SLTQ_RST_THRESH   32'h0000_0000
`define SLTQ_RST_DWELL    32'h0000_0000
`define SLTQ_RST_SPEED    32'h0000_0000
`define SLTQ_RST_TORQUE   32'h0000_0000

`define SLTQ_RESP_OKAY    2'h0
`define SLTQ_RESP_SLVERR  2'h2

`define SLTQ_CLK_NS       4
`define SLTQ_SAMPLE_NS    1000
`define SLTQ_SAMPLE_CYC   (`SLTQ_SAMPLE_NS / `SLTQ_CLK_NS)

`endif

//--- verif/sltq_switch_assertions.sv
// Checker for sltq_switch: register bus handshakes and sample timing.
// Assumes it is bound to the top module and given the same SAMPLE_DIV.
`timescale 1ns/10ps
`default_nettype none
module sltq_switch_assertions #(
    parameter SAMPLE_DIV = 250
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] vel_loop_torque,
    input wire logic [31:0] torque_setpoint,
    input wire logic        speed_ctrl_on,
    input wire logic        sample_strobe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [15:0] gap_r;
    logic        seen_r;
    // Gap counter: first strobe after reset has no reference phase
    always_ff @(posedge sys_clk) begin
        gap_r  <= (!nrst || sample_strobe) ? 16'h0000 : gap_r + 16'h0001;
        seen_r <= nrst && (seen_r || sample_strobe);
    end
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing wrong");
    AST_TICK_PERIOD: assert property (sample_strobe && seen_r |->
        gap_r == SAMPLE_DIV - 1) else $error("sample period wrong");
    AST_SETPT_HOLD: assert property (!sample_strobe |->
        $stable(torque_setpoint)) else $error("setpoint moved between samples");
    AST_MODE_HOLD: assert property (!sample_strobe |->
        $stable(speed_ctrl_on)) else $error("regulation moved between samples");
    AST_VEL_SETPT: assert property (sample_strobe && speed_ctrl_on |->
        torque_setpoint == $past(vel_loop_torque)) else $error("velocity setpoint wrong");
endmodule
bind sltq_switch sltq_switch_assertions #(.SAMPLE_DIV(SAMPLE_DIV)) u_sltq_chk (
    .sys_clk         (sys_clk),
    .nrst            (nrst),
    .s_axi_awvalid   (s_axi_awvalid),
    .s_axi_awready   (s_axi_awready),
    .s_axi_wvalid    (s_axi_wvalid),
    .s_axi_wready    (s_axi_wready),
    .s_axi_bresp     (s_axi_bresp),
    .s_axi_bvalid    (s_axi_bvalid),
    .s_axi_bready    (s_axi_bready),
    .s_axi_arvalid   (s_axi_arvalid),
    .s_axi_arready   (s_axi_arready),
    .s_axi_rdata     (s_axi_rdata),
    .s_axi_rvalid    (s_axi_rvalid),
    .s_axi_rready    (s_axi_rready),
    .vel_loop_torque (vel_loop_torque),
    .torque_setpoint (torque_setpoint),
    .speed_ctrl_on   (speed_ctrl_on),
    .sample_strobe   (sample_strobe)
);
`default_nettype wire

//--- verif/sltq_ctrl_model.sv
// Motion controller model: AXI4-Lite master that writes commands and config.
// Assumes the bench calls its tasks one at a time, right after a clock edge.
`timescale 1ns/10ps
`default_nettype none
`include "sltq_defs.vh"
module sltq_ctrl_model (
    input  wire logic        sys_clk,
    output logic [7:0]  s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [7:0]  s_axi_araddr,
    output logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        // Released payload toggles so a stale value is never mistaken for live
        s_axi_awaddr <= ~a;
        s_axi_wdata  <= ~d;
        while (!s_axi_bvalid) @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        while (!s_axi_rvalid) @(posedge sys_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic send_cmd(input logic [31:0] spd, input logic [31:0] trq);
        logic [1:0] r;
        wr(`SLTQ_OFS_SPEED, spd, 4'hf, r);
        wr(`SLTQ_OFS_TORQUE, trq, 4'hf, r);
    endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for sltq_switch: registers, disabled, min and max switching.
// Assumes the controller model drives the bus; this bench drives the plant side.
`timescale 1ns/10ps
`default_nettype none
`include "sltq_defs.vh"
module tb;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, speed_feedback, vel_loop_torque;
    logic [31:0] speed_reference, torque_setpoint, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, md;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        speed_ctrl_on, sample_strobe;
    logic signed [31:0] cmd, off, thr;
    int          error_cnt = 0, total_checks = 0, sg;
    integer      seed = 32'h0000_a222;
    always #2 sys_clk = ~sys_clk;
    sltq_switch #(.SAMPLE_DIV(4)) DUT (
        .sys_clk         (sys_clk),
        .nrst            (nrst),
        .s_axi_awaddr    (s_axi_awaddr),
        .s_axi_awvalid   (s_axi_awvalid),
        .s_axi_awready   (s_axi_awready),
        .s_axi_wdata     (s_axi_wdata),
        .s_axi_wstrb     (s_axi_wstrb),
        .s_axi_wvalid    (s_axi_wvalid),
        .s_axi_wready    (s_axi_wready),
        .s_axi_bresp     (s_axi_bresp),
        .s_axi_bvalid    (s_axi_bvalid),
        .s_axi_bready    (s_axi_bready),
        .s_axi_araddr    (s_axi_araddr),
        .s_axi_arvalid   (s_axi_arvalid),
        .s_axi_arready   (s_axi_arready),
        .s_axi_rdata     (s_axi_rdata),
        .s_axi_rresp     (s_axi_rresp),
        .s_axi_rvalid    (s_axi_rvalid),
        .s_axi_rready    (s_axi_rready),
        .speed_feedback  (speed_feedback),
        .vel_loop_torque (vel_loop_torque),
        .speed_reference (speed_reference),
        .torque_setpoint (torque_setpoint),
        .speed_ctrl_on   (speed_ctrl_on),
        .sample_strobe   (sample_strobe)
    );
    sltq_ctrl_model ctl (
        .sys_clk         (sys_clk),
        .s_axi_awaddr    (s_axi_awaddr),
        .s_axi_awvalid   (s_axi_awvalid),
        .s_axi_awready   (s_axi_awready),
        .s_axi_wdata     (s_axi_wdata),
        .s_axi_wstrb     (s_axi_wstrb),
        .s_axi_wvalid    (s_axi_wvalid),
        .s_axi_wready    (s_axi_wready),
        .s_axi_bresp     (s_axi_bresp),
        .s_axi_bvalid    (s_axi_bvalid),
        .s_axi_bready    (s_axi_bready),
        .s_axi_araddr    (s_axi_araddr),
        .s_axi_arvalid   (s_axi_arvalid),
        .s_axi_arready   (s_axi_arready),
        .s_axi_rdata     (s_axi_rdata),
        .s_axi_rresp     (s_axi_rresp),
        .s_axi_rvalid    (s_axi_rvalid),
        .s_axi_rready    (s_axi_rready)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Returns at the edge closing the strobe cycle; outputs hold until next tick
    task automatic tk;
        do @(posedge sys_clk); while (!sample_strobe);
    endtask
    function automatic logic [31:0] exp_sp(input logic [1:0] m,
            input logic signed [31:0] o, input logic signed [31:0] l);
        if (m == `SLTQ_MODE_MIN) return (o < l) ? o : l;
        return (o > l) ? o : l;
    endfunction
    task automatic summarize;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // A full run takes well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
    initial begin
        speed_feedback  = 32'h0000_0000;
        vel_loop_torque = 32'h0000_0000;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        ctl.rd(`SLTQ_OFS_CONFIG, d, r);
        chk(d, `SLTQ_RST_CONFIG);
        ctl.rd(`SLTQ_OFS_STATUS, d, r);
        chk(d, 32'h0000_0003);
        ctl.wr(`SLTQ_OFS_STATUS, 32'h0000_0000, 4'hf, r);
        chk(r, `SLTQ_RESP_SLVERR);
        ctl.rd(8'h20, d, r);
        chk(r, `SLTQ_RESP_SLVERR);
        chk(d, 32'h0000_0000);
        ctl.wr(`SLTQ_OFS_THRESH, 32'h1234_5678, 4'hf, r);
        ctl.wr(`SLTQ_OFS_THRESH, 32'haaaa_aaaa, 4'h2, r);
        ctl.rd(`SLTQ_OFS_THRESH, d, r);
        chk(d, 32'h1234_aa78);
        $display("test registers done");
        for (int m = 0; m < 2; m++) begin
            ctl.wr(`SLTQ_OFS_CONFIG, m ? 32'h0000_0003 : 32'h0000_0000, 4'hf, r);
            speed_feedback  <= $random(seed);
            vel_loop_torque <= $random(seed);
            tk();
            tk();
            chk(speed_ctrl_on, 1'b1);
            chk(torque_setpoint, vel_loop_torque);
        end
        $display("test disabled done");
        // Inversion only together with max, as the controller should choose
        for (int m = 0; m < 4; m++) begin
            md  = m[1] ? `SLTQ_MODE_MAX : `SLTQ_MODE_MIN;
            sg  = m[1] ? -1 : 1;
            cmd = $random(seed) >>> 8;
            off = $random(seed) >>> 8;
            thr = sg * ($random(seed) & 15);
            ctl.wr(`SLTQ_OFS_CONFIG, 32'h0000_0000, 4'hf, r);
            ctl.wr(`SLTQ_OFS_THRESH, thr, 4'hf, r);
            ctl.wr(`SLTQ_OFS_DWELL, 32'h0000_0003, 4'hf, r);
            ctl.send_cmd(cmd, off);
            vel_loop_torque <= $random(seed) >>> 8;
            speed_feedback  <= cmd - sg * 10;
            d = (m == 3) ? 32'h0000_0010 : 32'h0000_0000;
            ctl.wr(`SLTQ_OFS_CONFIG, d | md, 4'hf, r);
            tk();
            tk();
            chk(speed_ctrl_on, 1'b0);
            chk(torque_setpoint, exp_sp(md, off, vel_loop_torque));
            chk(speed_reference, cmd);
            ctl.rd(`SLTQ_OFS_SPD_ERR, d, r);
            chk(d, (m == 3) ? -(sg * 10) : sg * 10);
            speed_feedback <= cmd + sg;
            tk();
            tk();
            chk(speed_ctrl_on, 1'b1);
            chk(torque_setpoint, vel_loop_torque);
            speed_feedback <= cmd - thr - sg;
            tk();
            tk();
            speed_feedback <= cmd;
            tk();
            speed_feedback <= cmd - thr - sg;
            tk();
            tk();
            chk(speed_ctrl_on, 1'b1);
            tk();
            chk(speed_ctrl_on, 1'b0);
            $display("test switching %0d done", m);
        end
        summarize();
    end
endmodule
`default_nettype wire
